// *** asr_pkg.sv ***
`default_nettype none
package asr_pkg;
  // register offsets
  localparam logic [7:0] OFF_ADDR_SEL = 8'h00;
  localparam logic [7:0] OFF_COND = 8'h01;
  localparam logic [7:0] OFF_X_LO = 8'h02;
  localparam logic [7:0] OFF_X_HI = 8'h03;
  localparam logic [7:0] OFF_Y_LO = 8'h04;
  localparam logic [7:0] OFF_Y_HI = 8'h05;
  localparam logic [7:0] OFF_Z_LO = 8'h06;
  localparam logic [7:0] OFF_Z_HI = 8'h07;
  localparam logic [7:0] NUM_REGS = 8'h08;
  // field positions
  localparam int BIT_ADDR_SEL = 3;
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_CLK_GATED = 1;
  localparam int BIT_OTP_PWR = 5;
  localparam int BIT_WATCH = 6;
  localparam int BIT_DETECT = 7;
  // reserved bits 4:2 of the condition register read as this
  localparam logic [2:0] COND_RESV_VAL = 3'h1;
  // reset values
  localparam logic [7:0] RST_ADDR_SEL = 8'h00;
  localparam logic [7:0] RST_COND = 8'h04;
  localparam logic [7:0] RST_AXIS = 8'h00;
  // serial base addresses
  localparam logic [6:0] I2C_BASE_DEFAULT = 7'h4C;
  localparam logic [6:0] I2C_BASE_ALT = 7'h6C;
  // operating mode code for continuous wake
  localparam logic [2:0] MODE_CONT_WAKE = 3'h5;
  // sample widths
  localparam int LIVE_W = 14;
  localparam int FIFO_AXIS_W = 12;
  localparam int FIFO_WORD_W = 36;
  localparam int FIFO_DEPTH = 16;
endpackage
`default_nettype wire

// *** asr_readout.sv ***
`timescale 1ns/1ps
`default_nettype none

// sample fifo, flip-flop storage, count-based full and empty
module asr_fifo #(
  parameter int W = 36,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // count runs one bit wider than the index so that full and empty differ
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW+1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // storage words
    logic [AW-1:0] wr; // write index
    logic [AW-1:0] rd; // read index
    logic [AW:0] cnt; // words held
    logic rdy; // room left, kept as a flop for the ready port
  } asr_fifo_st_t;

  asr_fifo_st_t q;
  asr_fifo_st_t d;
  logic push;
  logic pop;

  // next-state: push and pop may share a cycle
  always_comb begin
    d = q;
    push = in_valid && (q.cnt != DEPTH);
    pop = out_ready && (q.cnt != '0);
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush) begin
      // flush drops the contents; storage left as is
      d.wr = '0;
      d.rd = '0;
      d.cnt = '0;
    end
    // ready registered from the next count, so it tracks the count exactly
    d.rdy = (d.cnt != DEPTH);
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.rdy <= 1'b1; // empty after reset, so there is room
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.rdy;
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rd];
endmodule // asr_fifo

// status and sample readout, register side on mclk, serial side on link_clk
module asr_readout (
  input wire logic mclk,
  input wire logic reset,
  // shared data-out / address strap pin
  input wire logic shared_dataout_addr_pin,
  // interface select bits from the feature register
  input wire logic iface_i2c_en,
  input wire logic iface_spi_en,
  input wire logic fifo_enable,
  // device condition inputs, same clock
  input wire logic clocks_gated,
  input wire logic otp_powered,
  input wire logic watch_active,
  input wire logic motion_detect,
  input wire logic [2:0] mode_code,
  // acceleration sample stream
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [13:0] x_axis_sample,
  input wire logic [13:0] y_axis_sample,
  input wire logic [13:0] z_axis_sample,
  // status outputs
  output logic address_select_latched,
  output logic continuous_wake_mode,
  output logic wake_request,
  // serial side, decoded transaction events
  input wire logic link_clk,
  input wire logic link_start,
  input wire logic link_stop,
  input wire logic [6:0] link_dev_addr,
  input wire logic link_rd,
  input wire logic [7:0] link_addr,
  output logic [7:0] link_rd_data,
  output logic link_addr_hit
);
  // core state on mclk; the register image the host reads is built here
  typedef struct packed {
    logic pin_s1; // strap synchroniser
    logic pin_s2;
    logic por_done; // strap already caught
    logic addr_sel; // latched address select
    logic ack_s1; // snapshot ack from link
    logic ack_s2;
    logic pop_s1; // six-byte read toggle from link
    logic pop_s2;
    logic pop_prev;
    logic watch_s; // previous watch level
    logic pub_tog; // snapshot offer toggle
    logic [7:0][7:0] pub; // offered register image
    logic [15:0] x; // live axis values
    logic [15:0] y;
    logic [15:0] z;
    logic unread; // live sample not yet read
    logic overrun;
    logic detect; // motion seen
    logic wake_mode; // continuous wake indication
    logic wake_req; // motion seen while watching
  } asr_core_st_t;

  // link state on link_clk; only toggles and the offered image cross over
  typedef struct packed {
    logic rst_s1; // reset synchroniser
    logic rst_s2;
    logic tog_s1; // offer toggle synchroniser
    logic tog_s2;
    logic ack; // ack toggle back to mclk
    logic [7:0][7:0] bank; // frozen image the host reads
    logic in_txn; // between start and stop
    logic [2:0] seq; // position in six-byte run
    logic pop_tog;
    logic [7:0] rd_data;
    logic hit;
  } asr_link_st_t;

  asr_core_st_t q;
  asr_core_st_t d;
  asr_link_st_t lq;
  asr_link_st_t ld;

  // glue between the core and the sample fifo
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [asr_pkg::FIFO_WORD_W-1:0] fifo_head;
  logic [asr_pkg::FIFO_WORD_W-1:0] fifo_word;
  logic fifo_push;
  logic fifo_pop;
  logic load_ok;
  logic accept;
  logic read_evt;

  // sign extension helpers
  // the top significant bit is copied into every bit above it
  function automatic logic [15:0] sext_live(input logic [13:0] v);
    sext_live = {{2{v[13]}}, v};
  endfunction

  function automatic logic [15:0] sext_fifo(input logic [11:0] v);
    sext_fifo = {{4{v[11]}}, v};
  endfunction

  // fifo word keeps the top twelve bits of each axis
  // the two lowest bits are dropped, the fifo word has no room for them
  assign fifo_word = {x_axis_sample[13:2], y_axis_sample[13:2], z_axis_sample[13:2]};
  // no measurement lands anywhere until an interface is chosen
  assign load_ok = iface_i2c_en || iface_spi_en;
  assign accept = smp_valid && fifo_in_ready && load_ok;
  assign fifo_push = accept && fifo_enable;
  // toggle edge from the link marks a completed six-byte read
  assign read_evt = q.pop_s2 != q.pop_prev;
  assign fifo_pop = read_evt && fifo_enable;

  // fifo disabled means flushed, so ready stays high in live mode
  // pushes and pops meet in the fifo's own next-state logic
  asr_fifo #(
    .W(asr_pkg::FIFO_WORD_W),
    .D(asr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst(reset),
    .flush(!fifo_enable),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_head)
  );

  // core next-state
  // link inputs reach this logic only through two flops
  always_comb begin
    logic [15:0] vx;
    logic [15:0] vy;
    logic [15:0] vz;
    logic ovr_set;
    vx = '0;
    vy = '0;
    vz = '0;
    ovr_set = 1'b0;
    d = q;
    // synchronisers and toggle followers
    d.pin_s1 = shared_dataout_addr_pin;
    d.pin_s2 = q.pin_s1;
    d.ack_s1 = lq.ack;
    d.ack_s2 = q.ack_s1;
    d.pop_s1 = lq.pop_tog;
    d.pop_s2 = q.pop_s1;
    d.pop_prev = q.pop_s2;
    d.watch_s = watch_active;
    // strap caught once, right after reset release
    if (!q.por_done) begin
      d.addr_sel = q.pin_s2;
      d.por_done = 1'b1;
    end
    // live sample load
    // a sample that lands on an unread one loses the older value
    if (accept && !fifo_enable) begin
      d.x = sext_live(x_axis_sample);
      d.y = sext_live(y_axis_sample);
      d.z = sext_live(z_axis_sample);
      d.unread = 1'b1;
      ovr_set = q.unread;
    end else if (read_evt) begin
      d.unread = 1'b0;
    end
    // a full fifo refusing a sample also loses data
    if (smp_valid && load_ok && fifo_enable && !fifo_in_ready) begin
      ovr_set = 1'b1;
    end
    // set beats the read clear in the same cycle
    d.overrun = ovr_set || (q.overrun && !read_evt);
    // detect sticks until a new watch period begins
    if (motion_detect) begin
      d.detect = 1'b1;
    end else if (watch_active && !q.watch_s) begin
      d.detect = 1'b0;
    end
    // mode decode registered, one cycle behind the mode input
    d.wake_mode = (mode_code == asr_pkg::MODE_CONT_WAKE);
    d.wake_req = motion_detect && watch_active;
    // axis view: fifo head when enabled, else live
    // an empty fifo reads as zero rather than a stale head
    if (fifo_enable) begin
      if (fifo_out_valid) begin
        vx = sext_fifo(fifo_head[35:24]);
        vy = sext_fifo(fifo_head[23:12]);
        vz = sext_fifo(fifo_head[11:0]);
      end
    end else begin
      vx = q.x;
      vy = q.y;
      vz = q.z;
    end
    // new image offered only when the link has taken the last one
    // the image trails the live values by one handshake round, so a host
    // polling faster than that round reads the previous sample again
    if (q.ack_s2 == q.pub_tog) begin
      d.pub = '0;
      d.pub[asr_pkg::OFF_ADDR_SEL][asr_pkg::BIT_ADDR_SEL] = q.addr_sel;
      d.pub[asr_pkg::OFF_COND][asr_pkg::BIT_OVERRUN] = q.overrun;
      d.pub[asr_pkg::OFF_COND][asr_pkg::BIT_CLK_GATED] = clocks_gated;
      d.pub[asr_pkg::OFF_COND][4:2] = asr_pkg::COND_RESV_VAL;
      d.pub[asr_pkg::OFF_COND][asr_pkg::BIT_OTP_PWR] = otp_powered;
      // watch circuitry never reports active in continuous wake
      d.pub[asr_pkg::OFF_COND][asr_pkg::BIT_WATCH] = watch_active && !q.wake_mode;
      d.pub[asr_pkg::OFF_COND][asr_pkg::BIT_DETECT] = q.detect;
      d.pub[asr_pkg::OFF_X_LO] = vx[7:0];
      d.pub[asr_pkg::OFF_X_HI] = vx[15:8];
      d.pub[asr_pkg::OFF_Y_LO] = vy[7:0];
      d.pub[asr_pkg::OFF_Y_HI] = vy[15:8];
      d.pub[asr_pkg::OFF_Z_LO] = vz[7:0];
      d.pub[asr_pkg::OFF_Z_HI] = vz[15:8];
      d.pub_tog = !q.pub_tog;
    end
  end

  // core register
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
      q.pub[asr_pkg::OFF_ADDR_SEL] <= asr_pkg::RST_ADDR_SEL;
      q.pub[asr_pkg::OFF_COND] <= asr_pkg::RST_COND;
      // strap synchroniser keeps running through reset, so the level is
      // settled when the first edge after release catches it
      q.pin_s1 <= d.pin_s1;
      q.pin_s2 <= d.pin_s2;
    end else begin
      q <= d;
    end
  end

  // link next-state
  always_comb begin
    logic [7:0] expect_addr;
    logic [6:0] base;
    // address that continues the six-byte run
    expect_addr = asr_pkg::OFF_X_LO + {5'h00, lq.seq};
    // base address follows the strap bit of the last copied image
    base = lq.bank[asr_pkg::OFF_ADDR_SEL][asr_pkg::BIT_ADDR_SEL] ? asr_pkg::I2C_BASE_ALT
                                                                 : asr_pkg::I2C_BASE_DEFAULT;
    ld = lq;
    ld.rst_s1 = reset;
    ld.rst_s2 = lq.rst_s1;
    ld.tog_s1 = q.pub_tog;
    ld.tog_s2 = lq.tog_s1;
    // start opens the freeze and restarts the run
    if (link_start) begin
      ld.in_txn = 1'b1;
      ld.seq = '0;
      ld.hit = (link_dev_addr == base);
    end
    // stop lifts the freeze
    if (link_stop) begin
      ld.in_txn = 1'b0;
    end
    // image taken only outside a transaction, so a burst stays coherent
    if ((lq.tog_s2 != lq.ack) && !lq.in_txn && !link_start) begin
      ld.bank = q.pub;
      ld.ack = lq.tog_s2;
    end
    // read answers from the frozen bank one edge after the request
    if (link_rd) begin
      ld.rd_data = (link_addr < asr_pkg::NUM_REGS) ? lq.bank[link_addr[2:0]] : 8'h00;
      // six-byte run must start at X low and walk to Z high
      if (link_addr == asr_pkg::OFF_X_LO) begin
        ld.seq = 3'h1;
      end else if ((lq.seq != 3'h0) && (link_addr == expect_addr)) begin
        if (link_addr == asr_pkg::OFF_Z_HI) begin
          ld.pop_tog = !lq.pop_tog;
          ld.seq = 3'h0;
        end else begin
          ld.seq = lq.seq + 3'h1;
        end
      end else begin
        ld.seq = 3'h0;
      end
    end
  end

  // link register; reset arrives through its own synchroniser
  // the reset bank shows the condition register at its reset value
  always_ff @(posedge link_clk) begin
    if (lq.rst_s2) begin
      lq <= '0;
      lq.rst_s1 <= ld.rst_s1;
      lq.rst_s2 <= ld.rst_s2;
      lq.bank[asr_pkg::OFF_COND] <= asr_pkg::RST_COND;
    end else begin
      lq <= ld;
    end
  end

  // every output is a flop bit, the ready one inside the fifo
  assign smp_ready = fifo_in_ready;
  assign address_select_latched = q.addr_sel;
  assign continuous_wake_mode = q.wake_mode;
  assign wake_request = q.wake_req;
  assign link_rd_data = lq.rd_data;
  assign link_addr_hit = lq.hit;
endmodule // asr_readout
`default_nettype wire

// *** asr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// port-level watcher for the readout block
module asr_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] mode_code,
  input wire logic motion_detect,
  input wire logic watch_active,
  input wire logic address_select_latched,
  input wire logic continuous_wake_mode,
  input wire logic wake_request,
  input wire logic link_clk,
  input wire logic link_start,
  input wire logic [6:0] link_dev_addr,
  input wire logic link_rd,
  input wire logic [7:0] link_addr,
  input wire logic [7:0] link_rd_data,
  input wire logic link_addr_hit
);
  // strap is caught once, then never follows the pin
  a_strap_hold: assert property (@(posedge mclk) disable iff (reset)
    $past(!reset) && $past(!reset, 2) |-> $stable(address_select_latched)) else $error("strap moved");
  a_strap_read: assert property (@(posedge link_clk) disable iff (reset)
    link_rd && link_addr == 8'h00 |=> link_rd_data == {4'h0, address_select_latched, 3'h0}) else $error("strap");
  a_addr_match: assert property (@(posedge link_clk) disable iff (reset)
    link_start |=> link_addr_hit == ($past(link_dev_addr) == (address_select_latched ?
    asr_pkg::I2C_BASE_ALT : asr_pkg::I2C_BASE_DEFAULT))) else $error("address match");
  a_hit_holds: assert property (@(posedge link_clk) disable iff (reset)
    !link_start |=> $stable(link_addr_hit)) else $error("hit moved");
  a_unmapped_zero: assert property (@(posedge link_clk) disable iff (reset)
    link_rd && link_addr >= asr_pkg::NUM_REGS |=> link_rd_data == 8'h00) else $error("unmapped");
  // read data only moves on a read request
  a_data_stands: assert property (@(posedge link_clk) disable iff (reset)
    !link_rd |=> $stable(link_rd_data)) else $error("data moved");
  a_wake_mode: assert property (@(posedge mclk) disable iff (reset)
    $past(!reset) |-> continuous_wake_mode == ($past(mode_code) == asr_pkg::MODE_CONT_WAKE)) else $error("mode");
  a_wake_request: assert property (@(posedge mclk) disable iff (reset)
    $past(!reset) |-> wake_request == $past(motion_detect && watch_active)) else $error("wake");
  c_wake: cover property (@(posedge mclk) wake_request);
  c_hit: cover property (@(posedge link_clk) link_addr_hit);
  c_read: cover property (@(posedge link_clk) link_rd && link_addr == 8'h07);
endmodule // asr_checker
bind asr_readout asr_checker asr_checker_inst (.mclk, .reset, .mode_code, .motion_detect, .watch_active,
  .address_select_latched, .continuous_wake_mode, .wake_request, .link_clk, .link_start,
  .link_dev_addr, .link_rd, .link_addr, .link_rd_data, .link_addr_hit);
`default_nettype wire

// *** asr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// host side of the link, decoded start, stop and byte reads
module asr_host (
  input wire logic link_clk,
  input wire logic [7:0] link_rd_data,
  output logic link_start = 1'h0,
  output logic link_stop = 1'h0,
  output logic [6:0] link_dev_addr = 7'h00,
  output logic link_rd = 1'h0,
  output logic [7:0] link_addr = 8'h00
);
  // open a transaction, address valid with the start pulse
  task automatic open_t(input logic [6:0] dev);
    @(posedge link_clk);
    link_start <= 1'h1;
    link_dev_addr <= dev;
    @(posedge link_clk);
    link_start <= 1'h0;
    link_dev_addr <= ~dev; // released, stale value inverted
    @(posedge link_clk);
  endtask
  // stop pulse ends the freeze
  task automatic close_t();
    @(posedge link_clk);
    link_stop <= 1'h1;
    @(posedge link_clk);
    link_stop <= 1'h0;
  endtask
  // byte read, data taken one edge after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge link_clk);
    link_rd <= 1'h1;
    link_addr <= a;
    @(posedge link_clk);
    link_rd <= 1'h0;
    link_addr <= ~a;
    @(posedge link_clk);
    d = link_rd_data;
  endtask
endmodule // asr_host
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// register-level bench for the readout block
module tb;
  logic mclk = 1'h0, link_clk = 1'h0, reset = 1'h1, shared_dataout_addr_pin = 1'h1;
  logic iface_i2c_en = 1'h0, iface_spi_en = 1'h0, fifo_enable = 1'h0, clocks_gated = 1'h0;
  logic otp_powered = 1'h0, watch_active = 1'h0, motion_detect = 1'h0, smp_valid = 1'h0;
  logic [2:0] mode_code = 3'h0;
  logic [13:0] x_axis_sample = 14'h0000, y_axis_sample = 14'h0000, z_axis_sample = 14'h0000;
  logic smp_ready, address_select_latched, continuous_wake_mode, wake_request;
  logic link_start, link_stop, link_rd, link_addr_hit;
  logic [6:0] link_dev_addr;
  logic [7:0] link_addr, link_rd_data, b;
  int n_fail = 0, n_checks = 0;
  always #10 mclk = ~mclk;
  // link edges never meet a core rising edge
  always #32 link_clk = ~link_clk;
  asr_readout asr_readout_inst (.mclk, .reset, .shared_dataout_addr_pin, .iface_i2c_en, .iface_spi_en,
    .fifo_enable, .clocks_gated, .otp_powered, .watch_active, .motion_detect, .mode_code, .smp_valid,
    .smp_ready, .x_axis_sample, .y_axis_sample, .z_axis_sample, .address_select_latched,
    .continuous_wake_mode, .wake_request, .link_clk, .link_start, .link_stop, .link_dev_addr,
    .link_rd, .link_addr, .link_rd_data, .link_addr_hit);
  asr_host asr_host_inst (.link_clk, .link_rd_data, .link_start, .link_stop, .link_dev_addr,
    .link_rd, .link_addr);
  // count and compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one sample on all axes, handshake held until ready
  task automatic push(input logic [13:0] v);
    @(posedge mclk);
    smp_valid <= 1'h1;
    x_axis_sample <= v;
    y_axis_sample <= ~v;
    z_axis_sample <= v ^ 14'h0aac;
    do @(posedge mclk); while (smp_ready !== 1'h1);
    smp_valid <= 1'h0;
  endtask
  // expected register pair, fifo keeps the top twelve bits
  function automatic logic [15:0] ex(input logic [13:0] s, input logic f);
    return f ? {{4{s[13]}}, s[13:2]} : {{2{s[13]}}, s};
  endfunction
  // single read in its own transaction, after a settle gap
  task automatic rd1(input logic [7:0] a, input logic [7:0] e);
    repeat (16) @(posedge link_clk);
    asr_host_inst.open_t(asr_pkg::I2C_BASE_ALT);
    asr_host_inst.rd(a, b);
    asr_host_inst.close_t();
    chk({8'h00, b}, {8'h00, e});
  endtask
  // six-byte burst, low byte first; z expects an output that never loaded
  task automatic rdv(input logic [13:0] v, input logic f, input logic z = 1'h0);
    logic [15:0] e [3];
    logic [7:0] lo;
    e = '{ex(v, f), ex(~v, f), ex(v ^ 14'h0aac, f)};
    if (z) e = '{16'h0000, 16'h0000, 16'h0000};
    repeat (16) @(posedge link_clk);
    asr_host_inst.open_t(asr_pkg::I2C_BASE_ALT);
    for (int i = 0; i < 3; i++) begin
      asr_host_inst.rd(8'(2 * i + 2), lo);
      asr_host_inst.rd(8'(2 * i + 3), b);
      chk({b, lo}, e[i]);
    end
    asr_host_inst.close_t();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog, about fifteen times the expected run
  initial begin
    #1_000_000;
    n_fail++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'h0;
    repeat (10) @(posedge link_clk);
    shared_dataout_addr_pin <= 1'h0;
    push(14'h2001);
    rd1(8'h00, 8'h08);
    rd1(8'h01, asr_pkg::RST_COND);
    rdv(14'h0000, 1'h0, 1'h1);
    rd1(8'h08, 8'h00);
    asr_host_inst.open_t(asr_pkg::I2C_BASE_DEFAULT);
    chk({15'h0000, link_addr_hit}, 16'h0000);
    asr_host_inst.close_t();
    asr_host_inst.open_t(asr_pkg::I2C_BASE_ALT);
    chk({15'h0000, link_addr_hit}, 16'h0001);
    asr_host_inst.close_t();
    $display("test reset done");
    iface_i2c_en <= 1'h1;
    push(14'h2001);
    rdv(14'h2001, 1'h0);
    push(14'h1555);
    push(14'h0aaa);
    rd1(8'h01, 8'h05);
    rdv(14'h0aaa, 1'h0);
    rd1(8'h01, 8'h04);
    asr_host_inst.open_t(asr_pkg::I2C_BASE_ALT);
    push(14'h0123);
    repeat (16) @(posedge link_clk);
    asr_host_inst.rd(8'h02, b);
    chk({8'h00, b}, 16'h00aa);
    asr_host_inst.close_t();
    rdv(14'h0123, 1'h0);
    $display("test live done");
    clocks_gated <= 1'h1;
    otp_powered <= 1'h1;
    watch_active <= 1'h1;
    rd1(8'h01, 8'h66);
    @(posedge mclk);
    motion_detect <= 1'h1;
    mode_code <= asr_pkg::MODE_CONT_WAKE;
    @(posedge mclk);
    motion_detect <= 1'h0;
    rd1(8'h01, 8'ha6);
    $display("test condition done");
    fifo_enable <= 1'h1;
    for (int i = 0; i < asr_pkg::FIFO_DEPTH; i++) push(14'(i * 14'h0411));
    repeat (3) @(posedge mclk);
    chk({15'h0000, smp_ready}, 16'h0000);
    asr_host_inst.open_t(asr_pkg::I2C_BASE_ALT);
    asr_host_inst.rd(8'h02, b);
    asr_host_inst.rd(8'h03, b);
    asr_host_inst.close_t();
    for (int i = 0; i < asr_pkg::FIFO_DEPTH; i++) rdv(14'(i * 14'h0411), 1'h1);
    chk({15'h0000, smp_ready}, 16'h0001);
    $display("test fifo done");
    conclude();
  end
endmodule // tb
`default_nettype wire
